/* mut_pkg.sv */
package mut_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h04;
  localparam logic [7:0] OFF_CLKSEL  = 8'h08;
  localparam logic [7:0] OFF_POWER   = 8'h0c;
  localparam logic [7:0] OFF_COUNT   = 8'h10;
  localparam logic [7:0] OFF_COMPARE = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_IEN     = 8'h1c;

  // Field positions
  localparam int CTRL_LOW_RUN   = 0;
  localparam int CTRL_HIGH_RUN  = 1;
  localparam int CTRL_COUNTER   = 2;
  localparam int CLK_SRC_BIT    = 2;
  localparam int PWR_DISABLE    = 0;
  localparam int PWR_DOWN       = 1;
  localparam int STS_LOW_OVF    = 0;
  localparam int STS_HIGH_OVF   = 1;

  // Reset values
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'hffff;
  localparam logic [1:0]  DIV_RST     = 2'h0;
  localparam logic [1:0]  POWER_RST   = 2'h0;

  // Mode encodings
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;
  localparam logic [1:0] SUB_A       = 2'h0;
  localparam logic [1:0] SUB_1B      = 2'h1;
  localparam logic [1:0] SUB_3B      = 2'h2;

  // Prescaler divider selections: 2, 4, 8
  localparam logic [1:0] DIV_2 = 2'h0;
  localparam logic [1:0] DIV_4 = 2'h1;
  localparam logic [1:0] DIV_8 = 2'h2;

  localparam logic [12:0] MAX13 = 13'h1fff;

  typedef struct packed {
    logic       counter_fn;
    logic       high_run_bit;
    logic       low_run_bit;
  } mut_ctrl_s;

  typedef struct packed {
    logic [1:0] sub_mode_sel;
    logic [1:0] main_mode_sel;
  } mut_mode_s;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} mut_shot_e;
endpackage

/* mut_timer.sv */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Counter only ever increments, up to 16 bits
// R2: Counter mode counts falling input edges
// R3: Main or low-power clock, divided 2/4/8
// R4: Counting starts from loaded count value
// R5: Separate low and high overflow flags
// R6: Run bits plus hardware trigger start counting
// R7: Compare match raises overflow in compare modes
// R8: Module disable bit stops whole timer
// R9: Flag set; interrupt only when enabled
// R10: Software clears flag in service routine
// R11: Mode 3 run bits control separate bytes
// R12: Main mode select encodes 0 to 3
// R13: Sub-mode select picks a or b variants
// R14: Power down holds reset and gates clock
// R15: Mode 0 is 13-bit timer, prescale 32
// R16: Mode 1a is free 16-bit counter
// R17: Mode 1b starts on event trigger
// R18: Mode 2 reloads low byte from high
// R19: Mode 3a runs two 8-bit counters
// R20: Mode 3b measures slow reference clock
// R21: Mode 0 overflows wrapping 1fff to 0
// R22: Mode 1b always starts from zero
// R23: Flag set on wrap, held until cleared
module mut_timer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Timing sources
  input  wire logic        main_clock,
  input  wire logic        low_power_clock,
  input  wire logic        count_input,
  input  wire logic        event_trigger,
  input  wire logic        slow_reference_clock,
  // Interrupt requests
  output logic             low_irq,
  output logic             high_irq
);

  mut_pkg::mut_ctrl_s ctrl;
  mut_pkg::mut_mode_s mode;
  mut_pkg::mut_shot_e shot;
  logic [2:0]  clock_divider_sel;
  logic [1:0]  power;
  logic [15:0] count;
  logic [15:0] compare_value;
  logic [1:0]  flags;
  logic [1:0]  ien;
  logic [2:0]  presc;
  logic        src_q;
  logic        cin_q;
  logic        ref_q;
  logic        next_tick;
  logic [2:0]  next_presc;
  logic [15:0] next_count;
  logic        next_low_ovf;
  logic        next_high_ovf;
  logic        next_start;

  wire logic wr = psel && penable && pwrite;
  wire logic wr_count = wr && pready && paddr == mut_pkg::OFF_COUNT;
  wire logic wr_status = wr && pready && paddr == mut_pkg::OFF_STATUS;
  // Either the disable bit or power down stops the whole timer
  wire logic module_off = power[mut_pkg::PWR_DISABLE] || power[mut_pkg::PWR_DOWN]; // R8 R14

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      mut_pkg::OFF_CTRL,
      mut_pkg::OFF_MODE,
      mut_pkg::OFF_CLKSEL,
      mut_pkg::OFF_POWER,
      mut_pkg::OFF_COUNT,
      mut_pkg::OFF_COMPARE,
      mut_pkg::OFF_STATUS,
      mut_pkg::OFF_IEN: mapped = 1'b1;
      default:          mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [8:0] inc8(input logic [7:0] v);
    inc8 = {1'b0, v} + 9'h001;
  endfunction

  // APB answers in the access cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
    end
  end

  // Read data is latched in the setup cycle and stands in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else begin
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          mut_pkg::OFF_CTRL:    prdata <= {29'h0, ctrl};
          mut_pkg::OFF_MODE:    prdata <= {28'h0, mode};
          mut_pkg::OFF_CLKSEL:  prdata <= {29'h0, clock_divider_sel};
          mut_pkg::OFF_POWER:   prdata <= {30'h0, power};
          mut_pkg::OFF_COUNT:   prdata <= {16'h0, count};
          mut_pkg::OFF_COMPARE: prdata <= {16'h0, compare_value};
          mut_pkg::OFF_STATUS:  prdata <= {30'h0, flags};
          mut_pkg::OFF_IEN:     prdata <= {30'h0, ien};
          default:              prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl              <= '0;
      mode              <= '0;
      clock_divider_sel <= {1'b0, mut_pkg::DIV_RST};
      power             <= mut_pkg::POWER_RST;
      compare_value     <= mut_pkg::COMPARE_RST;
      ien               <= 2'h0;
    end else if (wr && pready) begin
      case (paddr)
        mut_pkg::OFF_CTRL:    ctrl <= pwdata[2:0]; // R6
        mut_pkg::OFF_MODE:    mode <= pwdata[3:0]; // R12 R13
        mut_pkg::OFF_CLKSEL:  clock_divider_sel <= pwdata[2:0]; // R3
        mut_pkg::OFF_POWER:   power <= pwdata[1:0];
        mut_pkg::OFF_COMPARE: compare_value <= pwdata[15:0]; // R7
        mut_pkg::OFF_IEN:     ien <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Selected count source, one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 1'b0;
    end else begin
      src_q <= clock_divider_sel[mut_pkg::CLK_SRC_BIT] ? low_power_clock : main_clock;
    end
  end

  // Count pin history; a zero after reset cannot fake a falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cin_q <= 1'b0;
    end else begin
      cin_q <= count_input;
    end
  end

  // Slow reference history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= slow_reference_clock;
    end
  end

  wire logic src_now = clock_divider_sel[mut_pkg::CLK_SRC_BIT] ? low_power_clock : main_clock;
  wire logic src_rise = src_now && !src_q;
  wire logic cin_fall = cin_q && !count_input; // R2
  wire logic ref_rise = slow_reference_clock && !ref_q;

  // Prescaler: one tick per 2, 4 or 8 source edges
  always_comb begin
    next_presc = presc;
    next_tick  = 1'b0;
    if (src_rise) begin
      next_presc = presc + 3'h1;
      case (clock_divider_sel[1:0])
        mut_pkg::DIV_2: next_tick = presc[0]; // R3
        mut_pkg::DIV_4: next_tick = presc[1:0] == 2'h3; // R3
        default:        next_tick = presc == 3'h7; // R3
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 3'h0;
    end else if (module_off) begin
      presc <= 3'h0; // R14
    end else begin
      presc <= next_presc;
    end
  end

  wire logic tick = ctrl.counter_fn ? cin_fall : next_tick; // R2
  wire logic is_1b = mode.main_mode_sel == mut_pkg::MODE_16BIT && mode.sub_mode_sel == mut_pkg::SUB_1B;
  wire logic is_3b = mode.main_mode_sel == mut_pkg::MODE_SPLIT && mode.sub_mode_sel == mut_pkg::SUB_3B;
  assign next_start = event_trigger && ctrl.low_run_bit;

  // Single-shot sequencer for mode 1b
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shot <= mut_pkg::ST_IDLE;
    end else if (module_off || !is_1b || !ctrl.low_run_bit) begin
      shot <= mut_pkg::ST_IDLE;
    end else begin
      case (shot)
        mut_pkg::ST_IDLE:  shot <= mut_pkg::ST_ARMED;
        mut_pkg::ST_ARMED: if (next_start) shot <= mut_pkg::ST_RUN; // R17
        mut_pkg::ST_RUN:   if (tick && next_count == compare_value) shot <= mut_pkg::ST_ARMED; // R7
        default:           shot <= mut_pkg::ST_IDLE;
      endcase
    end
  end

  // Count update per mode, always upward
  always_comb begin
    logic [8:0]  lo;
    logic [8:0]  hi;
    logic [16:0] w;
    logic [13:0] m0;
    lo = inc8(count[7:0]);
    hi = inc8(count[15:8]);
    w  = {1'b0, count} + 17'h00001;
    m0 = {1'b0, count[15:8], count[4:0]} + 14'h0001;
    next_count    = count;
    next_low_ovf  = 1'b0;
    next_high_ovf = 1'b0;
    case (mode.main_mode_sel)
      mut_pkg::MODE_13BIT: begin
        if (tick && ctrl.low_run_bit) begin
          next_count = {m0[12:5], 3'h0, m0[4:0]}; // R15
          next_low_ovf = m0[13]; // R21
          next_high_ovf = m0[13];
        end
      end
      mut_pkg::MODE_16BIT: begin
        if (is_1b) begin
          // Count parks at the compare value until the next trigger
          if (shot == mut_pkg::ST_ARMED && next_start) begin
            next_count = 16'h0000; // R22
          end else if (shot == mut_pkg::ST_RUN && tick) begin
            next_count = w[15:0];
            next_low_ovf = w[16] || w[15:0] == compare_value; // R7
          end
        end else if (tick && ctrl.low_run_bit) begin
          next_count = w[15:0]; // R16 R1 R4
          next_low_ovf = w[16];
          next_high_ovf = w[16];
        end
      end
      mut_pkg::MODE_RELOAD: begin
        if (tick && ctrl.low_run_bit) begin
          next_count[7:0] = lo[8] ? count[15:8] : lo[7:0]; // R18
          next_low_ovf = lo[8] || lo[7:0] == compare_value[7:0]; // R7
        end
      end
      mut_pkg::MODE_SPLIT: begin
        if (is_3b) begin
          if (ref_rise && ctrl.low_run_bit) begin
            next_count[7:0] = lo[7:0]; // R20
            next_low_ovf = lo[8] || lo[7:0] == compare_value[7:0]; // R7
          end
          if (ctrl.high_run_bit) begin
            next_count[15:8] = ref_rise ? 8'h00 : (tick ? hi[7:0] : count[15:8]); // R20
            next_high_ovf = tick && !ref_rise && hi[8];
          end
        end else begin
          if (tick && ctrl.low_run_bit) begin
            next_count[7:0] = lo[7:0]; // R11 R19
            next_low_ovf = lo[8];
          end
          if (tick && ctrl.high_run_bit) begin
            next_count[15:8] = hi[7:0]; // R11 R19
            next_high_ovf = hi[8];
          end
        end
      end
      default: next_count = count;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= mut_pkg::COUNT_RST;
    end else if (module_off) begin
      count <= mut_pkg::COUNT_RST; // R14 R8
    end else if (wr_count) begin
      count <= pwdata[15:0]; // R4
    end else begin
      count <= next_count;
    end
  end

  // Sticky overflow flags; write one clears, a new overflow wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 2'h0;
    end else if (power[mut_pkg::PWR_DOWN]) begin
      flags <= 2'h0; // R14
    end else begin
      if (next_low_ovf && !module_off) begin
        flags[mut_pkg::STS_LOW_OVF] <= 1'b1; // R5 R23
      end else if (wr_status && pwdata[0]) begin
        flags[mut_pkg::STS_LOW_OVF] <= 1'b0; // R10
      end
      if (next_high_ovf && !module_off) begin
        flags[mut_pkg::STS_HIGH_OVF] <= 1'b1; // R5 R23
      end else if (wr_status && pwdata[1]) begin
        flags[mut_pkg::STS_HIGH_OVF] <= 1'b0; // R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_irq <= 1'b0;
    end else begin
      low_irq <= (flags[0] || (next_low_ovf && !module_off)) && ien[0]; // R9
    end
  end

  // Each request follows its sticky flag and its enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_irq <= 1'b0;
    end else begin
      high_irq <= (flags[1] || (next_high_ovf && !module_off)) && ien[1]; // R9
    end
  end

endmodule
`default_nettype wire

/* mut_timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mut_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Interrupts
  input wire logic        low_irq,
  input wire logic        high_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  logic bad;
  logic wr;
  assign setup = psel && !penable;
  assign bad   = (paddr > 8'h1c) || (paddr[1:0] != 2'h0);
  assign wr    = psel && pwrite;
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup && bad |=> pslverr)
    else $error("no error on bad address");
  a_ok_mapped: assert property (setup && !bad |=> !pslverr)
    else $error("error on mapped address");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_ctrl_reserved: assert property (
    pready && !pwrite && paddr == mut_pkg::OFF_CTRL |-> prdata[31:3] == 29'h0)
    else $error("control spare bits not zero");
  a_ien_quiets: assert property (
    pready && wr && paddr == mut_pkg::OFF_IEN && pwdata[1:0] == 2'h0
    |-> ##2 !low_irq && !high_irq)
    else $error("request without enable");
  a_pd_quiets: assert property (
    pready && wr && paddr == mut_pkg::OFF_POWER && pwdata[1]
    |-> ##3 (!low_irq && !high_irq) [*3])
    else $error("request during power down");
  a_irq_holds: assert property (low_irq && !$past(wr) && !wr ##1 !wr |=> low_irq)
    else $error("flag dropped without write");
  a_quiet_after_reset: assert property ($rose(presetn) |-> !low_irq && !high_irq && !pready)
    else $error("outputs active after reset");
  c_bad_addr: cover property (setup && bad);
  c_low_irq: cover property ($rose(low_irq));
  c_high_irq: cover property ($rose(high_irq));
endmodule
bind mut_timer mut_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .low_irq, .high_irq);
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam logic [7:0] CTL = mut_pkg::OFF_CTRL;
  localparam logic [7:0] MOD = mut_pkg::OFF_MODE;
  localparam logic [7:0] CKS = mut_pkg::OFF_CLKSEL;
  localparam logic [7:0] PWR = mut_pkg::OFF_POWER;
  localparam logic [7:0] CNT = mut_pkg::OFF_COUNT;
  localparam logic [7:0] CPV = mut_pkg::OFF_COMPARE;
  localparam logic [7:0] STS = mut_pkg::OFF_STATUS;
  localparam logic [7:0] IEN = mut_pkg::OFF_IEN;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        event_trigger, low_irq, high_irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  src;
  int          failures, checks;
  mut_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_clock(src[0]), .low_power_clock(src[1]),
    .count_input(src[2]), .event_trigger, .slow_reference_clock(src[3]), .low_irq, .high_irq);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus transfer; waits for ready under a bound
  task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    ap(1'b0, a, 32'h0);
    `CHK({err, rdat}, {1'b0, e})
  endtask
  // Rising edges on one timing source, two cycles each phase
  task pulse(input int s, input int n);
    repeat (n) begin
      src[s] <= 1'b1;
      repeat (2) @(posedge pclk);
      src[s] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task rst;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task t_regs;
    rst();
    rd(CPV, 32'hffff);
    rd(CNT, 32'h0);
    rd(PWR, 32'h0);
    ap(1'b0, 8'h20, 32'h0);
    `CHK({err, rdat}, 33'h100000000)
    ap(1'b1, 8'h16, 32'hff);
    `CHK(err, 1'b1)
    $display("regs done");
  endtask
  task t_wrap;
    rst();
    ap(1'b1, MOD, 32'h1);
    ap(1'b1, IEN, 32'h3);
    ap(1'b1, CNT, 32'hfffe);
    ap(1'b1, CTL, 32'h1);
    rd(CTL, 32'h1);
    pulse(0, 4);
    rd(CNT, 32'h0);
    rd(STS, 32'h3);
    `CHK({high_irq, low_irq}, 2'h3)
    ap(1'b1, STS, 32'h1);
    rd(STS, 32'h2);
    `CHK({high_irq, low_irq}, 2'h2)
    ap(1'b1, IEN, 32'h0);
    rd(STS, 32'h2);
    `CHK(high_irq, 1'b0)
    ap(1'b1, IEN, 32'h3);
    rd(STS, 32'h2);
    `CHK({high_irq, low_irq}, 2'h2)
    ap(1'b1, PWR, 32'h2);
    rd(STS, 32'h0);
    `CHK({high_irq, low_irq}, 2'h0)
    $display("wrap done");
  endtask
  task t_div;
    for (int i = 0; i < 3; i++) begin
      rst();
      ap(1'b1, MOD, 32'h1);
      ap(1'b1, CKS, {29'h0, 1'b1, i[1:0]});
      ap(1'b1, CTL, 32'h1);
      pulse(0, 8);
      pulse(1, 8);
      rd(CNT, 32'h8 >> (i + 1));
    end
    $display("div done");
  endtask
  task t_edges;
    rst();
    ap(1'b1, MOD, 32'h1);
    ap(1'b1, CTL, 32'h5);
    pulse(2, 3);
    pulse(0, 4);
    rd(CNT, 32'h3);
    $display("edges done");
  endtask
  task t_m0;
    rst();
    ap(1'b1, CNT, 32'h1f);
    ap(1'b1, CTL, 32'h1);
    pulse(0, 2);
    rd(CNT, 32'h100);
    rd(STS, 32'h0);
    ap(1'b1, CNT, 32'hff1f);
    pulse(0, 2);
    rd(CNT, 32'h0);
    rd(STS, 32'h3);
    $display("m0 done");
  endtask
  task t_m2;
    rst();
    ap(1'b1, MOD, 32'h2);
    ap(1'b1, CPV, 32'h0);
    ap(1'b1, CNT, 32'h80ff);
    ap(1'b1, CTL, 32'h1);
    pulse(0, 2);
    rd(CNT, 32'h8080);
    rd(STS, 32'h1);
    $display("m2 done");
  endtask
  task t_m3;
    rst();
    ap(1'b1, MOD, 32'h3);
    ap(1'b1, CNT, 32'h10ff);
    ap(1'b1, CTL, 32'h1);
    pulse(0, 2);
    rd(CNT, 32'h1000);
    rd(STS, 32'h1);
    ap(1'b1, CTL, 32'h2);
    ap(1'b1, CNT, 32'hff00);
    pulse(0, 2);
    rd(CNT, 32'h0);
    rd(STS, 32'h3);
    $display("m3 done");
  endtask
  task t_m3b;
    rst();
    ap(1'b1, MOD, 32'hb);
    ap(1'b1, CTL, 32'h3);
    pulse(3, 2);
    pulse(0, 4);
    rd(CNT, 32'h202);
    $display("m3b done");
  endtask
  task t_m1b;
    rst();
    ap(1'b1, MOD, 32'h5);
    ap(1'b1, CPV, 32'h3);
    ap(1'b1, CNT, 32'h1234);
    ap(1'b1, CTL, 32'h1);
    pulse(0, 4);
    rd(STS, 32'h0);
    event_trigger <= 1'b1;
    @(posedge pclk);
    event_trigger <= 1'b0;
    pulse(0, 4);
    rd(CNT, 32'h2);
    pulse(0, 2);
    rd(STS, 32'h1);
    $display("m1b done");
  endtask
  task t_off;
    rst();
    ap(1'b1, MOD, 32'h1);
    ap(1'b1, PWR, 32'h1);
    ap(1'b1, CTL, 32'h1);
    pulse(0, 8);
    rd(CNT, 32'h0);
    ap(1'b1, PWR, 32'h0);
    pulse(0, 4);
    rd(CNT, 32'h2);
    $display("off done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, event_trigger} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    src = 4'h0;
    failures = 0;
    checks = 0;
    t_regs();
    t_wrap();
    t_div();
    t_edges();
    t_m0();
    t_m2();
    t_m3();
    t_m3b();
    t_m1b();
    t_off();
    report_and_stop();
  end
endmodule
`default_nettype wire
